// ### hw/slbc_top.sv
// self-test checker top: pin sync, control fsm, pass output, ahb-lite registers
`timescale 1ns/1ns
module slbc_top
    import slbc_pkg::*;
#(
    parameter int payload_bits = slbc_payload_bits
)
(
    input wire logic clock,
    input wire logic reset,
    input wire logic self_test_enable_pin,
    input wire logic self_test_clock_select_pin,
    input wire logic pixel_clock_present,
    input wire logic rx_lock,
    input wire logic back_channel_detect,
    input wire logic frame_strobe,
    input wire logic [payload_bits-1:0] frame_payload,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output logic pass,
    output logic back_channel_test_request,
    output logic use_internal_oscillator,
    output logic test_active,
    output logic lock_status,
    output logic irq
);
    slbc_state_t state;
    slbc_state_t next_state;
    logic [1:0] pin_en_sync;
    logic [1:0] pin_clk_sync;
    logic [1:0] clk_present_sync;
    logic [1:0] lock_sync;
    logic [1:0] bc_sync;
    logic [31:0] control;
    logic [slbc_irq_width-1:0] irq_status;
    logic [slbc_irq_width-1:0] irq_mask;
    logic error_seen;
    logic wr_pending;
    logic [9:0] wr_addr;
    logic start_clear;

    slbc_ev_if ev ();

    // two-stage synchronisers; stage zero feeds only stage one
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            pin_en_sync <= 2'b00;
            pin_clk_sync <= 2'b00;
            clk_present_sync <= 2'b00;
            lock_sync <= 2'b00;
            bc_sync <= 2'b00;
        end
        else
        begin
            pin_en_sync <= {pin_en_sync[0], self_test_enable_pin};
            pin_clk_sync <= {pin_clk_sync[0], self_test_clock_select_pin};
            clk_present_sync <= {clk_present_sync[0], pixel_clock_present};
            lock_sync <= {lock_sync[0], rx_lock};
            bc_sync <= {bc_sync[0], back_channel_detect};
        end
    end

    // test requested by pin or register bit
    wire logic test_request = pin_en_sync[1] || control[slbc_ctl_test_enable];
    // oscillator only chosen when no pixel clock is present
    wire logic osc_choice = !clk_present_sync[1]
        && (pin_clk_sync[1] || control[slbc_ctl_osc_select]);
    wire logic locked = lock_sync[1];
    wire logic frame_err_event = ev.frame_valid && ev.frame_error;

    // control state machine
    always_comb
    begin
        next_state = state;
        case (state)
            slbc_idle:
                if (test_request)
                    next_state = slbc_wait_lock;
            slbc_wait_lock:
                if (!test_request)
                    next_state = slbc_idle;
                else if (locked)
                    next_state = slbc_checking;
            slbc_checking:
                if (!test_request)
                    next_state = slbc_idle;
            default:
                next_state = slbc_idle;
        endcase
    end

    assign start_clear = (state == slbc_idle) && test_request;

    always_ff @(posedge clock)
    begin
        if (reset)
            state <= slbc_idle;
        else
            state <= next_state;
    end

    slbc_frame_check #(
        .payload_bits(payload_bits)
    ) u_check (
        .clock(clock),
        .reset(reset),
        .checking(state == slbc_checking),
        .frame_strobe(frame_strobe),
        .frame_payload(frame_payload),
        .ev(ev.src)
    );

    slbc_err_counter u_count (
        .clock(clock),
        .reset(reset),
        .clear(start_clear),
        .ev(ev.cnt)
    );

    // pass output: live low pulses while checking, held result afterwards;
    // a half pixel period is below one cycle here, so a pulse is one cycle
    always_ff @(posedge clock)
    begin
        if (reset || start_clear)
            error_seen <= 1'b0;
        else if (frame_err_event && ev.active)
            error_seen <= 1'b1;
    end

    // keyed on the next state so pass is already high in the first checking cycle
    always_ff @(posedge clock)
    begin
        if (reset)
            pass <= 1'b1;
        else if (next_state == slbc_checking)
            pass <= !(frame_err_event && ev.active);
        else if (next_state == slbc_wait_lock)
            pass <= 1'b0;
        else
            pass <= !error_seen;
    end

    // back-channel request and status outputs
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            back_channel_test_request <= 1'b0;
            use_internal_oscillator <= 1'b0;
            test_active <= 1'b0;
            lock_status <= 1'b0;
        end
        else
        begin
            back_channel_test_request <= (next_state != slbc_idle);
            use_internal_oscillator <= osc_choice && (next_state != slbc_idle);
            test_active <= (next_state == slbc_checking);
            lock_status <= locked;
        end
    end

    // ahb-lite slave: zero wait states, always okay
    wire logic addr_phase = hsel && hready && htrans[1];
    wire logic [9:0] rd_addr = haddr[9:0];
    wire logic [slbc_irq_width-1:0] irq_events = {
        (state == slbc_checking) && (next_state == slbc_idle),
        frame_err_event && ev.active,
        (state == slbc_wait_lock) && (next_state == slbc_checking)
    };
    wire logic wr_ctl = wr_pending && (wr_addr == slbc_adr_control);
    wire logic wr_sts = wr_pending && (wr_addr == slbc_adr_irq_status);
    wire logic wr_msk = wr_pending && (wr_addr == slbc_adr_irq_mask);
    wire logic [31:0] rd_mux =
        (rd_addr == slbc_adr_link_detect_status) ? {30'h0, locked, bc_sync[1]} :
        (rd_addr == slbc_adr_forward_error_count) ? {24'h0, ev.err_count} :
        (rd_addr == slbc_adr_control) ? control :
        (rd_addr == slbc_adr_irq_status) ? {29'h0, irq_status} :
        (rd_addr == slbc_adr_irq_mask) ? {29'h0, irq_mask} : 32'h0;

    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            wr_pending <= 1'b0;
            wr_addr <= 10'h000;
            hrdata <= 32'h0000_0000;
        end
        else
        begin
            wr_pending <= addr_phase && hwrite;
            wr_addr <= rd_addr;
            if (addr_phase && !hwrite)
                hrdata <= rd_mux;
        end
    end

    always_ff @(posedge clock)
    begin
        hreadyout <= 1'b1;
        hresp <= 1'b0;
    end

    // control and mask registers
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            control <= slbc_ctl_reset;
            irq_mask <= '0;
        end
        else
        begin
            if (wr_ctl)
                control <= {30'h0, hwdata[1:0]};
            if (wr_msk)
                irq_mask <= hwdata[slbc_irq_width-1:0];
        end
    end

    // sticky status: a new event wins over a write-one clear
    always_ff @(posedge clock)
    begin
        if (reset)
            irq_status <= '0;
        else
            irq_status <= (irq_status & ~(wr_sts ? hwdata[slbc_irq_width-1:0] : '0))
                | irq_events;
    end

    always_ff @(posedge clock)
    begin
        if (reset)
            irq <= 1'b0;
        else
            irq <= |(irq_status & irq_mask);
    end
endmodule : slbc_top

// ### shared/slbc_pkg.sv
// package of constants and types for the serial link self-test checker
// Notes on behaviour
// - self-test entered by pin or register bit
// - test clock from pixel clock or oscillator
// - send self-test request over back channel
// - both in test and locked: pass high, check
// - each payload error pulses pass low briefly
// - compare to zeros, count errors at forward_error_count
// - on stop, pass holds the final result
// - held result lasts until new test or reset
// - lock indication valid throughout the test
// - link returns to normal after pin low (code also needs the control test-enable bit clear)
package slbc_pkg;
    // register byte addresses (printed offsets not all word multiples: index * 4)
    localparam logic [7:0] slbc_idx_link_detect_status = 8'h0c;
    localparam logic [7:0] slbc_idx_forward_error_count = 8'h25;
    localparam logic [7:0] slbc_idx_control = 8'h40;
    localparam logic [7:0] slbc_idx_irq_status = 8'h41;
    localparam logic [7:0] slbc_idx_irq_mask = 8'h42;
    localparam logic [9:0] slbc_adr_link_detect_status = {slbc_idx_link_detect_status, 2'b00};
    localparam logic [9:0] slbc_adr_forward_error_count = {slbc_idx_forward_error_count, 2'b00};
    localparam logic [9:0] slbc_adr_control = {slbc_idx_control, 2'b00};
    localparam logic [9:0] slbc_adr_irq_status = {slbc_idx_irq_status, 2'b00};
    localparam logic [9:0] slbc_adr_irq_mask = {slbc_idx_irq_mask, 2'b00};
    // control register fields
    localparam int slbc_ctl_test_enable = 0;
    localparam int slbc_ctl_osc_select = 1;
    // interrupt status fields
    localparam int slbc_irq_start = 0;
    localparam int slbc_irq_error = 1;
    localparam int slbc_irq_done = 2;
    localparam int slbc_irq_width = 3;
    // reset values
    localparam logic [31:0] slbc_ctl_reset = 32'h0000_0000;
    localparam logic [7:0] slbc_count_reset = 8'h00;
    // payload bits checked per received frame
    localparam int slbc_payload_bits = 35;
    localparam logic [1:0] slbc_htrans_nonseq = 2'b10;
    typedef enum logic [1:0] {slbc_idle, slbc_wait_lock, slbc_checking} slbc_state_t;
endpackage : slbc_pkg

// ### shared/slbc_ev_if.sv
// interface carrying checker events between submodules
`timescale 1ns/1ns
interface slbc_ev_if;
    logic active;
    logic frame_valid;
    logic frame_error;
    logic [7:0] err_count;
    modport src (output active, output frame_valid, output frame_error, input err_count);
    modport cnt (input active, input frame_valid, input frame_error, output err_count);
endinterface : slbc_ev_if

// ### hw/slbc_err_counter.sv
// saturating forward-channel error counter
`timescale 1ns/1ns
module slbc_err_counter
    import slbc_pkg::*;
(
    input wire logic clock,
    input wire logic reset,
    input wire logic clear,
    slbc_ev_if.cnt ev
);
    logic [7:0] count;
    wire logic bump = ev.active && ev.frame_valid && ev.frame_error && (count != 8'hff);

    // cleared at each test start, saturates rather than wrapping
    always_ff @(posedge clock)
    begin
        if (reset || clear)
            count <= slbc_count_reset;
        else if (bump)
            count <= count + 8'h01;
    end
    assign ev.err_count = count;
endmodule : slbc_err_counter

// ### hw/slbc_frame_check.sv
// compares each received frame's payload against all zeros
`timescale 1ns/1ns
module slbc_frame_check
    import slbc_pkg::*;
#(
    parameter int payload_bits = slbc_payload_bits
)
(
    input wire logic clock,
    input wire logic reset,
    input wire logic checking,
    input wire logic frame_strobe,
    input wire logic [payload_bits-1:0] frame_payload,
    slbc_ev_if.src ev
);
    // registered so the compare cone stays off the bus paths
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            ev.frame_valid <= 1'b0;
            ev.frame_error <= 1'b0;
            ev.active <= 1'b0;
        end
        else
        begin
            ev.active <= checking;
            ev.frame_valid <= frame_strobe && checking;
            ev.frame_error <= |frame_payload;
        end
    end
endmodule : slbc_frame_check

// ### sim/slbc_assertions.sv
// concurrent checks on the self-test checker top ports
`timescale 1ns/1ns
module slbc_assertions
#(
    parameter int payload_bits = slbc_pkg::slbc_payload_bits
)
(
    input wire logic clock,
    input wire logic reset,
    input wire logic self_test_enable_pin,
    input wire logic pixel_clock_present,
    input wire logic rx_lock,
    input wire logic frame_strobe,
    input wire logic [payload_bits-1:0] frame_payload,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic pass,
    input wire logic back_channel_test_request,
    input wire logic use_internal_oscillator,
    input wire logic test_active,
    input wire logic lock_status
);
    import slbc_pkg::*;
    wire err_frame = frame_strobe && (|frame_payload);
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    a_request_start: assert property ($rose(self_test_enable_pin)
        && !back_channel_test_request |-> ##[1:4] back_channel_test_request)
        else $error("self-test request not raised");
    a_active_request: assert property (test_active |-> back_channel_test_request)
        else $error("checking without request");
    a_pass_on_start: assert property ($rose(test_active) |-> pass)
        else $error("pass low at check start");
    a_error_pulse: assert property (test_active && err_frame |-> ##2 !pass)
        else $error("error frame gave no low pulse");
    a_low_has_cause: assert property (test_active && !pass |-> $past(err_frame, 2))
        else $error("pass low without error frame");
    a_lock_valid: assert property (rx_lock[*4] ##0 test_active |-> lock_status)
        else $error("lock status lost during test");
    a_result_held: assert property (!back_channel_test_request
        && !$past(back_channel_test_request, 3) && !$past(reset) |-> $stable(pass))
        else $error("held result changed");
    a_osc_choice: assert property (pixel_clock_present[*4] |-> !use_internal_oscillator)
        else $error("oscillator chosen with pixel clock");
    a_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus not ready or error response");
    a_stop_exit: assert property ($fell(back_channel_test_request) |-> !test_active)
        else $error("still checking after stop");
endmodule : slbc_assertions

bind slbc_top slbc_assertions #(.payload_bits(payload_bits)) slbc_assertions_inst (
    .clock, .reset, .self_test_enable_pin, .pixel_clock_present, .rx_lock, .frame_strobe,
    .frame_payload, .hreadyout, .hresp, .pass, .back_channel_test_request,
    .use_internal_oscillator, .test_active, .lock_status);

// ### sim/slbc_serializer_model.sv
// behavioural remote serializer: wakes on request, locks, sends zero frames
`timescale 1ns/1ns
module slbc_serializer_model
#(
    parameter int payload_bits = slbc_pkg::slbc_payload_bits
)
(
    input wire logic clock,
    input wire logic reset,
    input wire logic request,
    input wire logic slow,
    input wire logic inject,
    output logic rx_lock,
    output logic back_channel_detect,
    output logic frame_strobe,
    output logic [payload_bits-1:0] frame_payload,
    output logic [7:0] crc_errors
);
    import slbc_pkg::*;
    logic [7:0] age;
    logic pending;
    logic request_d;
    // slow mode models a serializer that must first power up
    wire locked = request && age >= (slow ? 8'h28 : 8'h03);
    wire send = locked && age[1:0] == 2'b00;
    // one error frame per inject pulse, end bits flipped to probe the payload edges
    always @(posedge clock)
    begin
        age <= (reset || !request) ? 8'h00 : age + {7'h00, age != 8'hff};
        rx_lock <= !reset && locked;
        back_channel_detect <= !reset && locked;
        frame_strobe <= !reset && send;
        // an inject landing on a send edge stays pending for the next frame
        pending <= !reset && request && (inject || (pending && !send));
        request_d <= !reset && request;
        // inject doubles as a back-channel crc fault, counted only once locked
        if (reset || (request && !request_d))
            crc_errors <= 8'h00;
        else if (locked && inject && crc_errors != 8'hff)
            crc_errors <= crc_errors + 8'h01;
        if (reset)
            frame_payload <= '1;
        else if (send)
            frame_payload <= pending ? {1'b1, {(payload_bits-2){1'b0}}, 1'b1} : '0;
        else
            frame_payload <= ~frame_payload;
    end
endmodule : slbc_serializer_model

// ### sim/slbc_top_tb.sv
// self-checking bench for the serial link self-test checker
`timescale 1ns/1ns
module slbc_top_tb;
    import slbc_pkg::*;
    typedef struct {logic [31:0] addr; logic [31:0] exp;} slbc_row_t;
    logic clock = 1'b0, reset = 1'b1, self_test_enable_pin = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic self_test_clock_select_pin = 1'b0, pixel_clock_present = 1'b1, slow = 1'b0;
    logic inject = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic [1:0] htrans = 2'b00;
    logic [2:0] hsize = 3'b010;
    logic hreadyout, hresp, pass, back_channel_test_request, use_internal_oscillator;
    logic test_active, lock_status, irq, rx_lock, back_channel_detect, frame_strobe;
    logic [slbc_payload_bits-1:0] frame_payload;
    logic [7:0] crc_errors;
    int n_fail = 0, checked = 0, n_low = 0;
    // reset values, with one unmapped place at the end
    slbc_row_t rows [6] = '{'{32'(slbc_adr_link_detect_status), 32'h0},
        '{32'(slbc_adr_forward_error_count), 32'(slbc_count_reset)},
        '{32'(slbc_adr_control), slbc_ctl_reset}, '{32'(slbc_adr_irq_status), 32'h0},
        '{32'(slbc_adr_irq_mask), 32'h0}, '{32'h0000_0200, 32'h0}};

    slbc_top slbc_top_inst (.clock, .reset, .self_test_enable_pin, .self_test_clock_select_pin,
        .pixel_clock_present, .rx_lock, .back_channel_detect, .frame_strobe, .frame_payload,
        .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata,
        .hreadyout, .hresp, .pass, .back_channel_test_request, .use_internal_oscillator,
        .test_active, .lock_status, .irq);
    slbc_serializer_model slbc_serializer_model_inst (.clock, .reset,
        .request(back_channel_test_request), .slow, .inject, .rx_lock, .back_channel_detect,
        .frame_strobe, .frame_payload, .crc_errors);

    initial
    begin
        forever #2 clock = ~clock;
    end
    // low pass cycles while checking, one per error frame
    always @(posedge clock)
    begin
        if (test_active === 1'b1 && pass === 1'b0)
            n_low <= n_low + 1;
    end

    task automatic report_and_stop;
        if (n_fail == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : report_and_stop

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask : check

    // bounded wait on hreadyout (0) or test_active (1); running out ends the run
    task automatic wait_on(input int w, input logic want, input int limit);
        int k;
        k = 0;
        do
        begin
            @(posedge clock);
            k++;
        end
        while ((w == 0 ? hreadyout : test_active) !== want && k < limit);
        check("wait outcome", {31'h0, w == 0 ? hreadyout : test_active}, {31'h0, want});
        if ((w == 0 ? hreadyout : test_active) !== want)
            report_and_stop;
    endtask : wait_on

    // one single-word ahb-lite transfer, address phase then data phase
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
        @(posedge clock);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= slbc_htrans_nonseq;
        hwrite <= wr;
        wait_on(0, 1'b1, 20);
        htrans <= 2'b00;
        hsel <= 1'b0;
        hwdata <= d;
        wait_on(0, 1'b1, 20);
        rd = hrdata;
    endtask : bus

    initial
    begin
        repeat (2) @(posedge clock);
        reset <= 1'b0;
        foreach (rows[i])
        begin
            bus(1'b0, rows[i].addr, 32'h0);
            check("register reset", rd, rows[i].exp);
        end
        bus(1'b1, 32'(slbc_adr_forward_error_count), 32'hff);
        bus(1'b0, 32'(slbc_adr_forward_error_count), 32'h0);
        check("read-only count", rd, 32'h0);
        // pin-started test with three error frames, error events unmasked
        bus(1'b1, 32'(slbc_adr_irq_mask), 32'h2);
        // board straps are fixed outside this block; pin width sets test length
        self_test_enable_pin <= 1'b1;
        wait_on(1, 1'b1, 100);
        check("pass at start", {31'h0, pass}, 32'h1);
        check("lock in test", {31'h0, lock_status}, 32'h1);
        bus(1'b0, 32'(slbc_adr_link_detect_status), 32'h0);
        check("link detect", rd, 32'h3);
        repeat (3)
        begin
            inject <= 1'b1;
            @(posedge clock);
            inject <= 1'b0;
            repeat (8) @(posedge clock);
        end
        check("error pulses", 32'(n_low), 32'h3);
        bus(1'b0, 32'(slbc_adr_forward_error_count), 32'h0);
        check("error count", rd, 32'h3);
        check("irq raised", {31'h0, irq}, 32'h1);
        bus(1'b1, 32'(slbc_adr_irq_mask), 32'h0);
        repeat (2) @(posedge clock);
        check("irq masked", {31'h0, irq}, 32'h0);
        bus(1'b1, 32'(slbc_adr_irq_mask), 32'h2);
        repeat (2) @(posedge clock);
        check("irq unmasked", {31'h0, irq}, 32'h1);
        bus(1'b1, 32'(slbc_adr_irq_status), 32'h2);
        repeat (2) @(posedge clock);
        check("irq cleared", {31'h0, irq}, 32'h0);
        self_test_enable_pin <= 1'b0;
        wait_on(1, 1'b0, 50);
        repeat (2) @(posedge clock);
        check("failed result", {31'h0, pass}, 32'h0);
        check("request dropped", {31'h0, back_channel_test_request}, 32'h0);
        bus(1'b0, 32'(slbc_adr_irq_status), 32'h0);
        check("events after stop", rd, 32'h5);
        check("crc count held", {24'h0, crc_errors}, 32'h3);
        repeat (20) @(posedge clock);
        check("result held", {31'h0, pass}, 32'h0);
        reset <= 1'b1;
        repeat (2) @(posedge clock);
        reset <= 1'b0;
        @(posedge clock);
        check("result after reset", {31'h0, pass}, 32'h1);
        // register-started clean test, slow serializer, oscillator without pixel clock
        slow <= 1'b1;
        pixel_clock_present <= 1'b0;
        self_test_clock_select_pin <= 1'b1;
        bus(1'b1, 32'(slbc_adr_control), 32'h1);
        wait_on(1, 1'b1, 200);
        check("oscillator chosen", {31'h0, use_internal_oscillator}, 32'h1);
        check("crc count cleared", {24'h0, crc_errors}, 32'h0);
        // pixel clock returns mid-test, so the choice must drop while still checking
        pixel_clock_present <= 1'b1;
        repeat (4) @(posedge clock);
        check("pixel clock chosen", {31'h0, use_internal_oscillator}, 32'h0);
        repeat (26) @(posedge clock);
        bus(1'b0, 32'(slbc_adr_forward_error_count), 32'h0);
        check("clean count", rd, 32'h0);
        bus(1'b1, 32'(slbc_adr_control), 32'h0);
        wait_on(1, 1'b0, 50);
        repeat (2) @(posedge clock);
        check("clean result", {31'h0, pass}, 32'h1);
        report_and_stop;
    end
endmodule : slbc_top_tb
